/* src/mcm_defines.vh */
// Constants for the monitor configuration and alert mask register bank
// Contract
// - Local offset is signed, half-degree steps, added to every local result
// - Second remote offset is signed, half-degree steps, added to every remote two result
// - With global lock set, offset, config two and mask one registers ignore writes
// - Fan sense bit one selects two-wire sensing, only in low-frequency mode
// - Averaging-disable bit one stops averaging of temperature and voltage conversions
// - Attenuator-bypass bit one removes the attenuator from the core supply input
// - Single-channel bit one converts only the input chosen by external select field
// - Select codes: 001 core, 010 3.3 V, 101/110/111 temperatures, others reserved
// - Shutdown drives all fan outputs to fans-off level, inverted when selected
// - While shut down every current duty cycle reads zero
// - Channel mask bits stop that channel's out-of-limit event reaching the alert
// - Top mask bit stops all second-status-register conditions reaching the alert
// - All four registers reset to zero
`ifndef MCM_DEFINES_VH
`define MCM_DEFINES_VH

// Register indices; byte address is four times the index
`define MCM_IDX_LOCAL_OFS 10'h071
`define MCM_IDX_REMOTE2_OFS 10'h072
`define MCM_IDX_CONFIG_TWO 10'h073
`define MCM_IDX_MASK_ONE 10'h074
`define MCM_IDX_ALERT_STATUS 10'h080
`define MCM_IDX_ALERT_IRQ_MASK 10'h081

`define MCM_ADDR_LOCAL_OFS ({`MCM_IDX_LOCAL_OFS, 2'b00})
`define MCM_ADDR_REMOTE2_OFS ({`MCM_IDX_REMOTE2_OFS, 2'b00})
`define MCM_ADDR_CONFIG_TWO ({`MCM_IDX_CONFIG_TWO, 2'b00})
`define MCM_ADDR_MASK_ONE ({`MCM_IDX_MASK_ONE, 2'b00})
`define MCM_ADDR_ALERT_STATUS ({`MCM_IDX_ALERT_STATUS, 2'b00})
`define MCM_ADDR_ALERT_IRQ_MASK ({`MCM_IDX_ALERT_IRQ_MASK, 2'b00})

`define MCM_RESET_BYTE 8'h00

// Configuration two fields
`define MCM_CFG_SENSE_LSB 0
`define MCM_CFG_SENSE_MSB 3
`define MCM_CFG_AVG_DIS 4
`define MCM_CFG_ATTENUATOR_BYPASS_BYP 5
`define MCM_CFG_SINGLE 6
`define MCM_CFG_SHUTDOWN 7

// Mask and status layout
`define MCM_MSK_CORE 1
`define MCM_MSK_SUP33 2
`define MCM_MSK_REMOTE1 4
`define MCM_MSK_LOCAL 5
`define MCM_MSK_REMOTE2 6
`define MCM_MSK_STATUS2 7
`define MCM_MSK_VALID 8'hF6

// Single-channel select codes
`define MCM_SEL_CORE 3'h1
`define MCM_SEL_SUP33 3'h2
`define MCM_SEL_REMOTE1 3'h5
`define MCM_SEL_LOCAL 3'h6
`define MCM_SEL_REMOTE2 3'h7

`endif

/* src/mcm_offset_add.v */
// Signed offset correction of one temperature channel
`timescale 1ns/1ps
module mcm_offset_add
(
   input wire ref_clk,
   input wire sys_rst,
   input wire [9:0] rawTemp,
   input wire rawValid,
   input wire [7:0] offsetCode,
   output reg [9:0] corrTemp,
   output reg corrValid
);
   wire [11:0] rawExt;
   wire [11:0] ofsExt;
   wire [11:0] sum;
   reg [9:0] satSum;

   // Offset step is half a degree, result step a quarter
   assign rawExt = {{2{rawTemp[9]}}, rawTemp};
   assign ofsExt = {{3{offsetCode[7]}}, offsetCode, 1'b0};
   assign sum = rawExt + ofsExt;

   // Saturate rather than wrap, a wrapped reading would mislead the fan loop
   always @*
   begin
      satSum = sum[9:0];
      if (sum[11:9] != {3{sum[11]}})
      begin
         satSum = sum[11] ? 10'h200 : 10'h1FF;
      end
   end

   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         corrTemp <= 10'h000;
         corrValid <= 1'b0;
      end
      else
      begin
         corrValid <= rawValid;
         if (rawValid)
         begin
            corrTemp <= satSum;
         end
      end
   end
endmodule // mcm_offset_add

/* src/mcm_fan_gate.v */
// Shutdown gating of one fan drive output and its duty readback
`timescale 1ns/1ps
module mcm_fan_gate
(
   input wire ref_clk,
   input wire sys_rst,
   input wire shutdown,
   input wire invert,
   input wire driveIn,
   input wire [7:0] dutyIn,
   output reg driveOut,
   output reg [7:0] dutyOut
);
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         driveOut <= 1'b0;
         dutyOut <= 8'h00;
      end
      else
      begin
         driveOut <= shutdown ? invert : driveIn;
         dutyOut <= shutdown ? 8'h00 : dutyIn;
      end
   end
endmodule // mcm_fan_gate

/* src/mcm_regs_top.v */
// APB register bank for offsets, configuration two and alert mask one
`timescale 1ns/1ps
`include "mcm_defines.vh"
module mcm_regs_top
(
   input wire ref_clk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire globalLock,
   input wire lowFreqMode,
   input wire drivePolarityInvert,
   input wire [2:0] channelSelect,
   input wire [9:0] localTempRaw,
   input wire localTempValid,
   input wire [9:0] remoteTwoTempRaw,
   input wire remoteTwoTempValid,
   output wire [9:0] localTempCorr,
   output wire localTempCorrValid,
   output wire [9:0] remoteTwoTempCorr,
   output wire remoteTwoTempCorrValid,
   output reg [3:0] twoWireSense,
   output reg averagingDisable,
   output reg attenuatorBypass,
   output reg singleChannelConvert,
   output reg [2:0] convertChannel,
   output reg convertChannelReserved,
   input wire [3:0] fanDriveIn,
   input wire [31:0] dutyCycleIn,
   output wire [3:0] fanDriveOut,
   output wire [31:0] dutyCycleOut,
   input wire coreSupplyOol,
   input wire supply33Ool,
   input wire remoteOneOol,
   input wire localOol,
   input wire remoteTwoOol,
   input wire statusTwoOol,
   output wire alertOut,
   output wire alertIrq
);
   ////////////////////////////////////////////////////////////////////////
   // Register storage
   reg [7:0] localOffset_reg;
   reg [7:0] localOffset_next;
   reg [7:0] remoteTwoOffset_reg;
   reg [7:0] remoteTwoOffset_next;
   reg [7:0] configTwo_reg;
   reg [7:0] configTwo_next;
   reg [7:0] maskOne_reg;
   reg [7:0] maskOne_next;
   reg [7:0] alertStatus_reg;
   reg [7:0] alertStatus_next;
   reg [7:0] irqMask_reg;
   reg [7:0] irqMask_next;
   reg [7:0] readByte;
   reg addrHit;
   reg lockedTarget;

   wire setupPhase;
   wire accessPhase;
   wire writeStrobe;
   wire lowLane;
   wire [7:0] wrByte;
   wire [7:0] eventVec;
   wire shutdownOn;
   wire hitLocalOfs;
   wire hitRemoteTwoOfs;
   wire hitConfigTwo;
   wire hitMaskOne;
   wire hitAlertStatus;
   wire hitIrqMask;
   wire writeOpen;

   ////////////////////////////////////////////////////////////////////////
   // APB handshake
   assign setupPhase = psel & ~penable;
   assign accessPhase = psel & penable;
   // Zero wait states, read data is staged in the setup cycle
   assign pready = 1'b1;
   assign pslverr = accessPhase & ~addrHit;
   assign lowLane = pstrb[0];
   assign wrByte = pwdata[7:0];
   assign writeStrobe = accessPhase & pwrite & addrHit & lowLane;

   ////////////////////////////////////////////////////////////////////////
   // Per-register hits, shared by the write and clear paths
   assign hitLocalOfs = (paddr == `MCM_ADDR_LOCAL_OFS);
   assign hitRemoteTwoOfs = (paddr == `MCM_ADDR_REMOTE2_OFS);
   assign hitConfigTwo = (paddr == `MCM_ADDR_CONFIG_TWO);
   assign hitMaskOne = (paddr == `MCM_ADDR_MASK_ONE);
   assign hitAlertStatus = (paddr == `MCM_ADDR_ALERT_STATUS);
   assign hitIrqMask = (paddr == `MCM_ADDR_ALERT_IRQ_MASK);

   // Lock blocks writes to the offset, config two and mask one registers
   // Locked writes end without an error, software sees no difference
   assign writeOpen = writeStrobe & ~(globalLock & lockedTarget);

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   always @*
   begin
      addrHit = 1'b1;
      lockedTarget = 1'b1;
      case (paddr)
         `MCM_ADDR_LOCAL_OFS:
         begin
            readByte = localOffset_reg;
         end
         `MCM_ADDR_REMOTE2_OFS:
         begin
            readByte = remoteTwoOffset_reg;
         end
         `MCM_ADDR_CONFIG_TWO:
         begin
            readByte = configTwo_reg;
         end
         `MCM_ADDR_MASK_ONE:
         begin
            readByte = maskOne_reg;
         end
         `MCM_ADDR_ALERT_STATUS:
         begin
            readByte = alertStatus_reg;
            lockedTarget = 1'b0;
         end
         `MCM_ADDR_ALERT_IRQ_MASK:
         begin
            readByte = irqMask_reg;
            lockedTarget = 1'b0;
         end
         default:
         begin
            readByte = 8'h00;
            addrHit = 1'b0;
            lockedTarget = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state of the writable registers
   always @*
   begin
      localOffset_next = localOffset_reg;
      remoteTwoOffset_next = remoteTwoOffset_reg;
      configTwo_next = configTwo_reg;
      maskOne_next = maskOne_reg;
      irqMask_next = irqMask_reg;
      if (writeOpen && hitLocalOfs)
      begin
         localOffset_next = wrByte;
      end
      if (writeOpen && hitRemoteTwoOfs)
      begin
         remoteTwoOffset_next = wrByte;
      end
      if (writeOpen && hitConfigTwo)
      begin
         configTwo_next = wrByte;
      end
      if (writeOpen && hitMaskOne)
      begin
         maskOne_next = wrByte & `MCM_MSK_VALID;
      end
      if (writeOpen && hitIrqMask)
      begin
         irqMask_next = wrByte & `MCM_MSK_VALID;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky alert status
   assign eventVec[0] = 1'b0;
   assign eventVec[`MCM_MSK_CORE] = coreSupplyOol;
   assign eventVec[`MCM_MSK_SUP33] = supply33Ool;
   assign eventVec[3] = 1'b0;
   assign eventVec[`MCM_MSK_REMOTE1] = remoteOneOol;
   assign eventVec[`MCM_MSK_LOCAL] = localOol;
   assign eventVec[`MCM_MSK_REMOTE2] = remoteTwoOol;
   assign eventVec[`MCM_MSK_STATUS2] = statusTwoOol;

   always @*
   begin
      alertStatus_next = alertStatus_reg;
      if (writeStrobe && hitAlertStatus)
      begin
         alertStatus_next = alertStatus_reg & ~wrByte;
      end
      alertStatus_next = (alertStatus_next | eventVec) & `MCM_MSK_VALID;
   end

   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         localOffset_reg <= `MCM_RESET_BYTE;
         remoteTwoOffset_reg <= `MCM_RESET_BYTE;
         configTwo_reg <= `MCM_RESET_BYTE;
         maskOne_reg <= `MCM_RESET_BYTE;
         alertStatus_reg <= `MCM_RESET_BYTE;
         irqMask_reg <= `MCM_RESET_BYTE;
      end
      else
      begin
         localOffset_reg <= localOffset_next;
         remoteTwoOffset_reg <= remoteTwoOffset_next;
         configTwo_reg <= configTwo_next;
         maskOne_reg <= maskOne_next;
         alertStatus_reg <= alertStatus_next;
         irqMask_reg <= irqMask_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, staged in the setup cycle so the access phase needs no wait
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prdata <= 32'h00000000;
      end
      else if (setupPhase)
      begin
         // Writes read back zero
         prdata <= pwrite ? 32'h00000000 : {24'h000000, readByte};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Alert gating
   // Per-channel masking
   // Second-status group masking
   // Mask one acts on the alert pin, the interrupt mask on the bus interrupt
   assign alertOut = |(alertStatus_reg & ~maskOne_reg & `MCM_MSK_VALID);
   assign alertIrq = |(alertStatus_reg & ~irqMask_reg & `MCM_MSK_VALID);

   ////////////////////////////////////////////////////////////////////////
   // Configuration outputs
   assign shutdownOn = configTwo_reg[`MCM_CFG_SHUTDOWN];

   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         twoWireSense <= 4'h0;
         averagingDisable <= 1'b0;
         attenuatorBypass <= 1'b0;
         singleChannelConvert <= 1'b0;
      end
      else
      begin
         twoWireSense <= configTwo_reg[`MCM_CFG_SENSE_MSB:`MCM_CFG_SENSE_LSB] & {4{lowFreqMode}};
         averagingDisable <= configTwo_reg[`MCM_CFG_AVG_DIS];
         attenuatorBypass <= configTwo_reg[`MCM_CFG_ATTENUATOR_BYPASS_BYP];
         singleChannelConvert <= configTwo_reg[`MCM_CFG_SINGLE];
      end
   end

   // Reserved select codes are flagged, never blocked
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         convertChannel <= 3'h0;
         // Code 000 is reserved, so the flag comes up set
         convertChannelReserved <= 1'b1;
      end
      else
      begin
         convertChannel <= channelSelect;
         case (channelSelect)
            `MCM_SEL_CORE,
            `MCM_SEL_SUP33,
            `MCM_SEL_REMOTE1,
            `MCM_SEL_LOCAL,
            `MCM_SEL_REMOTE2: convertChannelReserved <= 1'b0;
            default: convertChannelReserved <= 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Offset correction
   // Local offset applied
   mcm_offset_add localAdd
   (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .rawTemp(localTempRaw),
      .rawValid(localTempValid),
      .offsetCode(localOffset_reg),
      .corrTemp(localTempCorr),
      .corrValid(localTempCorrValid)
   );

   mcm_offset_add remoteTwoAdd
   (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .rawTemp(remoteTwoTempRaw),
      .rawValid(remoteTwoTempValid),
      .offsetCode(remoteTwoOffset_reg),
      .corrTemp(remoteTwoTempCorr),
      .corrValid(remoteTwoTempCorrValid)
   );

   ////////////////////////////////////////////////////////////////////////
   // Fan shutdown gating
   genvar fanIdx;
   generate
      for (fanIdx = 0; fanIdx < 4; fanIdx = fanIdx + 1)
      begin : fanGate
         mcm_fan_gate gate
         (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .shutdown(shutdownOn),
            .invert(drivePolarityInvert),
            .driveIn(fanDriveIn[fanIdx]),
            .dutyIn(dutyCycleIn[fanIdx*8 +: 8]),
            .driveOut(fanDriveOut[fanIdx]),
            .dutyOut(dutyCycleOut[fanIdx*8 +: 8])
         );
      end
   endgenerate
endmodule // mcm_regs_top

/* test/mcm_regs_sva.sv */
// Port assertions for the register bank
`timescale 1ns/1ps
module mcm_regs_sva
(
   input wire ref_clk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire globalLock,
   input wire lowFreqMode,
   input wire drivePolarityInvert,
   input wire localTempValid,
   input wire localTempCorrValid,
   input wire remoteTwoTempValid,
   input wire remoteTwoTempCorrValid,
   input wire [3:0] twoWireSense,
   input wire averagingDisable,
   input wire attenuatorBypass,
   input wire singleChannelConvert,
   input wire [2:0] convertChannel,
   input wire convertChannelReserved,
   input wire [3:0] fanDriveIn,
   input wire [31:0] dutyCycleIn,
   input wire [3:0] fanDriveOut,
   input wire [31:0] dutyCycleOut,
   input wire coreSupplyOol,
   input wire supply33Ool,
   input wire remoteOneOol,
   input wire localOol,
   input wire remoteTwoOol,
   input wire statusTwoOol,
   input wire alertOut
);
default clocking cb @(posedge ref_clk);
endclocking
default disable iff (sys_rst);
////////////////////////////////////////
chk_local_valid: assert property (localTempCorrValid == $past(localTempValid))
   else $error("local corrected valid not one cycle after raw");
chk_remote_valid: assert property (remoteTwoTempValid |=> remoteTwoTempCorrValid)
   else $error("remote two corrected valid missing");
// Locked or absent write must not move config outputs
chk_cfg_cause: assert property (
   $changed({averagingDisable, attenuatorBypass, singleChannelConvert})
   |-> $past(psel && penable && pwrite && !globalLock, 2))
   else $error("config output changed without unlocked write");
chk_sense_mode: assert property (!$past(lowFreqMode) |-> twoWireSense == 4'h0)
   else $error("two-wire sense outside low-frequency mode");
chk_resv_code: assert property (
   convertChannelReserved == (convertChannel == 3'h0 || convertChannel == 3'h3 || convertChannel == 3'h4))
   else $error("reserved channel flag wrong");
chk_fans_off: assert property (
   fanDriveOut != $past(fanDriveIn) |-> fanDriveOut == {4{$past(drivePolarityInvert)}})
   else $error("fan drive not at off level");
chk_duty_zero: assert property (dutyCycleOut != $past(dutyCycleIn) |-> dutyCycleOut == 32'h0)
   else $error("duty readback not zero");
chk_alert_cause: assert property ($rose(alertOut) |-> $past(coreSupplyOol || supply33Ool ||
   remoteOneOol || localOol || remoteTwoOol || statusTwoOol || (psel && penable && pwrite)))
   else $error("alert rose without event or write");
endmodule // mcm_regs_sva
bind mcm_regs_top mcm_regs_sva u_mcm_regs_sva (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .globalLock,
   .lowFreqMode, .drivePolarityInvert, .localTempValid, .localTempCorrValid, .remoteTwoTempValid,
   .remoteTwoTempCorrValid, .twoWireSense, .averagingDisable, .attenuatorBypass, .singleChannelConvert,
   .convertChannel, .convertChannelReserved, .fanDriveIn, .dutyCycleIn, .fanDriveOut, .dutyCycleOut,
   .coreSupplyOol, .supply33Ool, .remoteOneOol, .localOol, .remoteTwoOol, .statusTwoOol, .alertOut);

/* test/mcm_apb_host.sv */
// APB host model reaching the register bank
`timescale 1ns/1ps
module mcm_apb_host
(
   input wire ref_clk,
   output logic psel = 1'h0,
   output logic penable = 1'h0,
   output logic pwrite = 1'h0,
   output logic [11:0] paddr = 12'h0,
   output logic [31:0] pwdata = 32'h0,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr
);
// Request held until pready seen at an edge
task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q, output e);
   @(posedge ref_clk);
   psel <= 1'h1;
   pwrite <= w;
   paddr <= a;
   pwdata <= d;
   @(posedge ref_clk);
   penable <= 1'h1;
   @(posedge ref_clk);
   while (!pready) @(posedge ref_clk);
   q = prdata;
   e = pslverr;
   psel <= 1'h0;
   penable <= 1'h0;
endtask
endmodule // mcm_apb_host

/* test/testbench.sv */
// Self-checking bench for the monitor register bank
`timescale 1ns/1ps
`include "mcm_defines.vh"
module testbench;
localparam [11:0] OF = `MCM_ADDR_LOCAL_OFS;
localparam [11:0] ST = `MCM_ADDR_ALERT_STATUS;
logic ref_clk = 1'h0, sys_rst = 1'h1, globalLock = 1'h0, lowFreqMode = 1'h0, drivePolarityInvert = 1'h0;
logic [2:0] channelSelect = 3'h0;
logic signed [9:0] localTempRaw = 10'h0, remoteTwoTempRaw = 10'h0;
logic localTempValid = 1'h0, remoteTwoTempValid = 1'h0;
logic [3:0] fanDriveIn = 4'h0;
logic [31:0] dutyCycleIn = 32'h0, q, v;
logic [5:0] ev = 6'h0;
logic e;
logic signed [7:0] o0, o1;
wire psel, penable, pwrite, pready, pslverr, localTempCorrValid, remoteTwoTempCorrValid, alertOut, alertIrq;
wire averagingDisable, attenuatorBypass, singleChannelConvert, convertChannelReserved;
wire [11:0] paddr;
wire [31:0] pwdata, prdata, dutyCycleOut;
wire [9:0] localTempCorr, remoteTwoTempCorr;
wire [3:0] twoWireSense, fanDriveOut;
wire [2:0] convertChannel;
integer n_fail = 0, checked = 0, cyc = 0, i, j;
logic [7:0] mdl [0:3];
int pos [6] = '{1, 2, 4, 5, 6, 7};
always #12.5 ref_clk = ~ref_clk;
mcm_regs_top u_mcm_regs_top (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
   .prdata, .pready, .pslverr, .globalLock, .lowFreqMode, .drivePolarityInvert, .channelSelect, .localTempRaw,
   .localTempValid, .remoteTwoTempRaw, .remoteTwoTempValid, .localTempCorr, .localTempCorrValid,
   .remoteTwoTempCorr, .remoteTwoTempCorrValid, .twoWireSense, .averagingDisable, .attenuatorBypass,
   .singleChannelConvert, .convertChannel, .convertChannelReserved, .fanDriveIn, .dutyCycleIn, .fanDriveOut,
   .dutyCycleOut, .coreSupplyOol(ev[0]), .supply33Ool(ev[1]), .remoteOneOol(ev[2]), .localOol(ev[3]),
   .remoteTwoOol(ev[4]), .statusTwoOol(ev[5]), .alertOut, .alertIrq);
mcm_apb_host u_mcm_apb_host (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
////////////////////////////////////////
task chk(input [63:0] got, input [63:0] exp);
   checked = checked + 1;
   if (got !== exp)
   begin
      n_fail = n_fail + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
   end
endtask
task wr(input [11:0] a, input [7:0] d);
   u_mcm_apb_host.xfer(1'h1, a, {24'h0, d}, q, e);
endtask
task rd(input [11:0] a, input [31:0] x);
   u_mcm_apb_host.xfer(1'h0, a, $urandom, q, e);
   chk({e, q}, {1'h0, x});
endtask
// Saturating to the 10-bit result range
function [9:0] sat(input integer x);
   sat = x > 511 ? 10'h1FF : x < -512 ? 10'h200 : x[9:0];
endfunction
task tally_and_finish;
   if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
   else
      $display("TESTS FAILED");
   $finish;
endtask
always @(posedge ref_clk)
begin
   cyc <= cyc + 1;
   if (cyc == 20000)
   begin
      n_fail = n_fail + 1;
      tally_and_finish;
   end
end
////////////////////////////////////////
initial
begin
   repeat (6) @(posedge ref_clk);
   sys_rst <= 1'h0;
   v = $urandom(37464);
   for (i = 0; i < 6; i++) rd(i < 4 ? OF + 4 * i : ST + 4 * (i - 4), 32'h0);
   for (i = 0; i < 4; i++)
   begin
      v = $urandom;
      mdl[i] = i == 3 ? v[7:0] & `MCM_MSK_VALID : v[7:0];
      wr(OF + 4 * i, v[7:0]);
      rd(OF + 4 * i, mdl[i]);
   end
   u_mcm_apb_host.xfer(1'h0, 12'h1D4, 32'h0, q, e);
   chk({e, q}, {1'h1, 32'h0});
   globalLock <= 1'h1;
   for (i = 0; i < 4; i++)
   begin
      wr(OF + 4 * i, ~mdl[i]);
      rd(OF + 4 * i, mdl[i]);
   end
   globalLock <= 1'h0;
   // Saturating extremes first, then random
   for (i = 0; i < 6; i++)
   begin
      v = $urandom;
      o0 = i == 0 ? 8'h7F : i == 1 ? 8'h80 : v[7:0];
      o1 = v[15:8];
      wr(OF, o0);
      wr(OF + 4, o1);
      localTempRaw <= i == 0 ? 10'h1FF : i == 1 ? 10'h200 : v[25:16];
      remoteTwoTempRaw <= v[31:22];
      localTempValid <= 1'h1;
      remoteTwoTempValid <= 1'h1;
      @(posedge ref_clk);
      localTempValid <= 1'h0;
      remoteTwoTempValid <= 1'h0;
      @(negedge ref_clk);
      chk({localTempCorrValid, localTempCorr}, {1'h1, sat(localTempRaw + 2 * o0)});
      chk({remoteTwoTempCorrValid, remoteTwoTempCorr}, {1'h1, sat(remoteTwoTempRaw + 2 * o1)});
      @(posedge ref_clk);
   end
   for (j = 0; j < 8; j++)
   begin
      v = $urandom;
      channelSelect <= j[2:0];
      lowFreqMode <= v[8];
      wr(OF + 8, v[7:0]);
      repeat (2) @(posedge ref_clk);
      chk({twoWireSense, averagingDisable}, {v[3:0] & {4{v[8]}}, v[4]});
      chk({attenuatorBypass, singleChannelConvert}, {v[5], v[6]});
      chk({convertChannel, convertChannelReserved}, {j[2:0], j == 0 || j == 3 || j == 4});
   end
   for (j = 0; j < 4; j++)
   begin
      v = $urandom;
      drivePolarityInvert <= j[0];
      fanDriveIn <= v[3:0];
      dutyCycleIn <= $urandom;
      wr(OF + 8, {j[1], 7'h0});
      repeat (2) @(posedge ref_clk);
      chk({fanDriveOut, dutyCycleOut}, j[1] ? {{4{j[0]}}, 32'h0} : {fanDriveIn, dutyCycleIn});
   end
   // Each event unmasked then masked
   for (j = 0; j < 12; j++)
   begin
      wr(OF + 12, j[0] ? 8'hFF : 8'h00);
      wr(ST + 4, j[0] ? 8'hFF : 8'h00);
      ev <= 6'h1 << (j / 2);
      @(posedge ref_clk);
      ev <= 6'h0;
      @(posedge ref_clk);
      chk({alertOut, alertIrq}, {2{~j[0]}});
      rd(ST, 32'h1 << pos[j / 2]);
      wr(ST, 8'hFF);
      @(posedge ref_clk);
      chk({alertOut, alertIrq}, 2'h0);
   end
   tally_and_finish;
end
endmodule // testbench
